// ==== dv/bst_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module bst_host (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // Test clock stands low between frames
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end
  // Change right after fall, sample tdo just before rise
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #40;
    q = tdo_i;
    tck_o = 1'h1;
    #40;
    tck_o = 1'h0;
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'h1, 1'h0, q);
    step(1'h0, 1'h0, q);
  endtask
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
      output logic [15:0] dout);
    logic q;
    dout = 16'h0;
    step(1'h1, tdi_o, q);
    if (ir) step(1'h1, tdi_o, q);
    step(1'h0, tdi_o, q);
    step(1'h0, tdi_o, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'h1, ~din[n-1], q);
    step(1'h0, ~din[n-1], q);
    // Released data line shows inverse, not a stale bit
    tdi_o = ~din[n-1];
  endtask
  task automatic pins(input logic c, input logic m, input logic d);
    tck_o = c;
    tms_o = m;
    tdi_o = d;
  endtask
endmodule // bst_host
`default_nettype wire

// ==== dv/tb_boundary_scan_tap_logic.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_boundary_scan_tap_logic;
  typedef struct packed {
    logic [2:0] code;
    logic mode;
    logic [1:0] ring;
    logic [1:0] kind;
  } bst_row_t;
  // Kind 0 one-flop path, 1 internal ring, 2 pad chain
  localparam bst_row_t ROWS [8] = '{
    '{3'h0, 1'h1, 2'h0, 2'h2}, '{3'h1, 1'h0, 2'h1, 2'h1},
    '{3'h2, 1'h0, 2'h0, 2'h0}, '{3'h3, 1'h0, 2'h0, 2'h0},
    '{3'h4, 1'h0, 2'h0, 2'h2}, '{3'h5, 1'h0, 2'h2, 2'h1},
    '{3'h6, 1'h0, 2'h0, 2'h0}, '{3'h7, 1'h0, 2'h0, 2'h0}};
  localparam logic [20:0] WM = 21'h1f4f52;
  localparam logic [3:0] WS [21] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h7, 4'h5,
    4'h4, 4'h6, 4'h7, 4'hc, 4'h3, 4'hd, 4'hf, 4'he, 4'ha, 4'hb, 4'h9, 4'h8,
    4'h3, 4'hd, 4'h0};
  localparam logic [7:0] PDAT = 8'ha5;
  localparam logic [7:0] PDIR = 8'h3c;
  logic clk_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, mode_o, q;
  logic scan_tdi_o, cfg_wr_o, cfg_bit_o, rb_shift_o;
  logic resetn_i = 1'h0;
  logic powerup_reset_in_i = 1'h0;
  logic reprogram_in_i = 1'h0;
  logic rb_bit_i = 1'h0;
  logic [2:0] user_pins_o;
  logic [7:0] pad_in_i = 8'h0;
  logic [7:0] core_out_i = 8'h0;
  logic [7:0] core_oe_i = 8'h0;
  logic [7:0] pad_out_o, pad_oe_o;
  logic [1:0] ring_sdo_i = 2'h3;
  logic [1:0] ring_sel_o, rr;
  logic [15:0] din, dout, cfg_sh;
  logic [31:0] rd;
  bst_pkg::bst_strb_t strb_o;
  bst_pkg::bst_axi_req_t axi_req_i = '0;
  bst_pkg::bst_axi_rsp_t axi_rsp_o;
  wire logic tdo_w;
  int errors = 0;
  int checked = 0;
  int cfg_n = 0;
  int rb_n = 0;
  int ui_n = 0;
  int t;

  bst_tap #(.NPADS(8)) dut (.clk_i, .resetn_i, .tck_i, .tms_i, .tdi_i,
    .powerup_reset_in_i, .reprogram_in_i, .tdo_o, .tdo_oe_o, .user_pins_o,
    .pad_in_i, .core_out_i, .core_oe_i, .pad_out_o, .pad_oe_o, .mode_o,
    .strb_o, .ring_sdo_i, .ring_sel_o, .scan_tdi_o, .cfg_wr_o, .cfg_bit_o,
    .rb_bit_i, .rb_shift_o, .axi_req_i, .axi_rsp_o);
  bst_host host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_w));
  assign tdo_w = tdo_oe_o ? tdo_o : 1'bz;

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  always @(posedge clk_i) begin
    if (cfg_wr_o === 1'h1) begin
      cfg_n++;
      cfg_sh <= {cfg_bit_o, cfg_sh[15:1]};
    end
    if (rb_shift_o === 1'h1) rb_n++;
    if (strb_o.up_ir === 1'h1) ui_n++;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkr(input logic [1:0] g, input logic [1:0] e);
    chk({30'h0, g}, {30'h0, e});
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    t = 0;
    @(posedge clk_i);
    axi_req_i.awaddr <= a;
    axi_req_i.wdata <= d;
    axi_req_i.wstrb <= s;
    axi_req_i.awvalid <= 1'h1;
    axi_req_i.wvalid <= 1'h1;
    axi_req_i.bready <= 1'h1;
    do begin
      @(posedge clk_i);
      t++;
      if (axi_rsp_o.awready) axi_req_i.awvalid <= 1'h0;
      if (axi_rsp_o.wready) axi_req_i.wvalid <= 1'h0;
    end while (axi_rsp_o.bvalid !== 1'h1 && t < 99);
    rr = axi_rsp_o.bresp;
    axi_req_i.bready <= 1'h0;
    chk(t < 99, 1'h1);
  endtask
  task automatic axr(input logic [7:0] a);
    t = 0;
    @(posedge clk_i);
    axi_req_i.araddr <= a;
    axi_req_i.arvalid <= 1'h1;
    axi_req_i.rready <= 1'h1;
    do begin
      @(posedge clk_i);
      t++;
      if (axi_rsp_o.arready) axi_req_i.arvalid <= 1'h0;
    end while (axi_rsp_o.rvalid !== 1'h1 && t < 99);
    rd = axi_rsp_o.rdata;
    rr = axi_rsp_o.rresp;
    axi_req_i.rready <= 1'h0;
    chk(t < 99, 1'h1);
  endtask
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    axr(8'h00);
    chk(rd, 32'h0);
    axr(8'h04);
    chk(rd, 32'h170);
    axw(8'h04, 32'hffffffff, 4'hf);
    chkr(rr, 2'h0);
    axw(8'h00, 32'h7, 4'he);
    axr(8'h00);
    chk(rd, 32'h0);
    axw(8'h08, 32'h1, 4'hf);
    chkr(rr, 2'h3);
    axr(8'h0c);
    chkr(rr, 2'h3);
    axr(8'h04);
    chk(rd, 32'h170);
    host.tap_reset();
    foreach (ROWS[k]) begin
      host.scan(1'h1, 3, {13'h0, ROWS[k].code}, dout);
      chk(dout[2:0], 3'h1);
      settle();
      ring_sdo_i <= ~ROWS[k].ring;
      cfg_n = 0;
      chk(mode_o, ROWS[k].mode);
      chk(ring_sel_o, ROWS[k].ring);
      axr(8'h04);
      chk(rd[8:0], {1'h1, 1'h0, ROWS[k].code, 4'h1});
      // Chain rows skip here so update flops keep reset zeros
      if (ROWS[k].kind != 2'h2) begin
        host.scan(1'h0, 8, 16'h00b4, dout);
        if (ROWS[k].kind == 2'h0) chk(dout[7:0], 8'h68);
        if (ROWS[k].kind == 2'h1) chk(dout[7:1], 7'h0);
      end
      if (ROWS[k].code == 3'h2) begin
        chk(cfg_n, 32'h8);
        chk(cfg_sh[15:8], 8'hb4);
      end
    end
    chk(rb_n, 32'h0);
    chk(ui_n, 32'h8);
    settle();
    pad_in_i <= 8'h69;
    core_out_i <= 8'h96;
    core_oe_i <= 8'h0f;
    host.scan(1'h1, 3, 16'h4, dout);
    host.scan(1'h0, 16, 16'h0, dout);
    settle();
    for (int j = 0; j < 8; j++) begin
      rr = {core_oe_i[7-j] ? core_out_i[7-j] : pad_in_i[7-j], core_oe_i[7-j]};
      chk({dout[2*j+1], dout[2*j]}, rr);
    end
    chk({mode_o, pad_out_o, pad_oe_o}, {1'h0, 8'h96, 8'h0f});
    host.scan(1'h1, 3, 16'h0, dout);
    for (int j = 0; j < 8; j++) begin
      din[15-2*j] = PDAT[j];
      din[14-2*j] = PDIR[j];
    end
    host.scan(1'h0, 16, din, dout);
    settle();
    chk({mode_o, pad_out_o, pad_oe_o}, {1'h1, 8'ha5, 8'h3c});
    axw(8'h00, 32'h3, 4'hf);
    axr(8'h00);
    chk(rd, 32'h3);
    axr(8'h04);
    chk(rd[8], 1'h1);
    rb_bit_i <= 1'h1;
    host.scan(1'h1, 3, 16'h6, dout);
    host.scan(1'h0, 8, 16'h0, dout);
    settle();
    chk(dout[7:1], 7'h7f);
    chk(rb_n, 32'h8);
    axw(8'h00, 32'h1, 4'hf);
    axr(8'h04);
    chk(rd[8], 1'h0);
    host.pins(1'h1, 1'h0, 1'h1);
    settle();
    chk({tdo_oe_o, user_pins_o, scan_tdi_o}, 5'hb);
    axw(8'h00, 32'h5, 4'hf);
    settle();
    chk({tdo_oe_o, tdo_o}, 2'h3);
    axw(8'h00, 32'h3, 4'hf);
    settle();
    chk(user_pins_o, 3'h0);
    host.pins(1'h0, 1'h1, 1'h0);
    axw(8'h00, 32'h0, 4'hf);
    repeat (5) host.step(1'h1, 1'h1, q);
    for (int i = 0; i < 21; i++) begin
      host.step(WM[i], 1'h1, q);
      settle();
      axr(8'h04);
      chk(rd[3:0], WS[i]);
    end
    for (int j = 0; j < 2; j++) begin
      host.tap_reset();
      host.scan(1'h1, 3, 16'h0, dout);
      settle();
      if (j == 0) powerup_reset_in_i <= 1'h1;
      else reprogram_in_i <= 1'h1;
      settle();
      powerup_reset_in_i <= 1'h0;
      reprogram_in_i <= 1'h0;
      settle();
      axr(8'h04);
      chk({mode_o, rd[8:0]}, {1'h0, 9'h170});
    end
    axw(8'h00, 32'h2, 4'hf);
    resetn_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    axr(8'h00);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule // tb_boundary_scan_tap_logic
`default_nettype wire

// ==== hdl/bst_tap.sv ====
// Behaviour
// R1 - Three-bit instruction register, eight codes
// R2 - EXTEST 000, SAMPLE 100, BYPASS 111
// R3 - Rings 001/101, cfg write 010, readback 110
// R4 - Reserved code 011 selects bypass flip-flop
// R5 - Two chain bits per pad, direction decides
// R6 - Sample captures all pads simultaneously, non-intrusive
// R7 - Ring instructions route through internal chains
// R8 - Config write loads serial data from input
// R9 - Readback shifts config data after completion
// R10 - Chain order: first top pad, clockwise
// R11 - Bypass is one flip-flop delay
// R12 - Active before/during config, option afterwards
// R13 - No identification register provided
// R14 - Disabled: pins user I/O, output floats/readback
// R15 - Sixteen states, steered by sampled mode select
// R16 - Reprogram and power-up reset the logic
// R17 - Register select, enable, per-register strobes
// R18 - Update loads instruction or output flops
// R19 - Data and direction cells, shift then update
// R20 - Direction low captures pad, high functional
// R21 - Test-mode high only for external test
// R22 - Sample on rising edge, output on falling
// R23 - External test drives pads on falling edge
// R24 - Host changes inputs on falling, max 10 MHz; bst_host clocks at 12.5 MHz
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "bst_defines.svh"
module bst_tap #(
  parameter int NPADS = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic powerup_reset_in_i,
  input wire logic reprogram_in_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [2:0] user_pins_o,
  input wire logic [NPADS-1:0] pad_in_i,
  input wire logic [NPADS-1:0] core_out_i,
  input wire logic [NPADS-1:0] core_oe_i,
  output logic [NPADS-1:0] pad_out_o,
  output logic [NPADS-1:0] pad_oe_o,
  output logic mode_o,
  output var bst_pkg::bst_strb_t strb_o,
  input wire logic [1:0] ring_sdo_i,
  output logic [1:0] ring_sel_o,
  output logic scan_tdi_o,
  output logic cfg_wr_o,
  output logic cfg_bit_o,
  input wire logic rb_bit_i,
  output logic rb_shift_o,
  input wire bst_pkg::bst_axi_req_t axi_req_i,
  output var bst_pkg::bst_axi_rsp_t axi_rsp_o
);
  localparam int W = 2 * NPADS;

  typedef struct packed {
    logic [4:0] in_f;
    logic [4:0] in_q;
    logic tck_d;
    logic [NPADS-1:0] pad_f;
    logic [NPADS-1:0] pad_q;
    bst_pkg::bst_tap_t st;
    logic [2:0] ir_sh;
    logic [2:0] ir;
    logic byp;
    logic [W-1:0] boundary_chain;
    logic [W-1:0] upd;
    logic tdo;
    logic tdo_oe;
    logic mode;
    bst_pkg::bst_strb_t strb;
    logic [1:0] ring_sel;
    logic scan_tdi;
    logic cfg_wr;
    logic cfg_bit;
    logic rb_shift;
    logic [NPADS-1:0] pout;
    logic [NPADS-1:0] poe;
    logic [2:0] user;
    logic [`BST_CTRL_W-1:0] ctrl;
    logic aw_ok;
    logic w_ok;
    logic [`BST_AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    bst_pkg::bst_axi_rsp_t rsp;
  } bst_st_t;

  bst_st_t s_reg;
  bst_st_t s_next;
  logic rise;
  logic fall;
  logic active;
  logic rst_req;
  logic bsr_on;
  logic sout;
  logic [W-1:0] cap;
  logic [NPADS-1:0] u_dat;
  logic [NPADS-1:0] u_dir;

  function automatic bst_pkg::bst_tap_t tap_step(bst_pkg::bst_tap_t st,
                                                 logic tms);
    case (st)
      bst_pkg::TAP_RESET: tap_step = tms ? bst_pkg::TAP_RESET
                                         : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_IDLE: tap_step = tms ? bst_pkg::TAP_SEL_DR
                                        : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_SEL_DR: tap_step = tms ? bst_pkg::TAP_SEL_IR
                                          : bst_pkg::TAP_CAP_DR;
      bst_pkg::TAP_CAP_DR: tap_step = tms ? bst_pkg::TAP_EX1_DR
                                          : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_SH_DR: tap_step = tms ? bst_pkg::TAP_EX1_DR
                                         : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_EX1_DR: tap_step = tms ? bst_pkg::TAP_UPD_DR
                                          : bst_pkg::TAP_PAU_DR;
      bst_pkg::TAP_PAU_DR: tap_step = tms ? bst_pkg::TAP_EX2_DR
                                          : bst_pkg::TAP_PAU_DR;
      bst_pkg::TAP_EX2_DR: tap_step = tms ? bst_pkg::TAP_UPD_DR
                                          : bst_pkg::TAP_SH_DR;
      bst_pkg::TAP_UPD_DR: tap_step = tms ? bst_pkg::TAP_SEL_DR
                                          : bst_pkg::TAP_IDLE;
      bst_pkg::TAP_SEL_IR: tap_step = tms ? bst_pkg::TAP_RESET
                                          : bst_pkg::TAP_CAP_IR;
      bst_pkg::TAP_CAP_IR: tap_step = tms ? bst_pkg::TAP_EX1_IR
                                          : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_SH_IR: tap_step = tms ? bst_pkg::TAP_EX1_IR
                                         : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_EX1_IR: tap_step = tms ? bst_pkg::TAP_UPD_IR
                                          : bst_pkg::TAP_PAU_IR;
      bst_pkg::TAP_PAU_IR: tap_step = tms ? bst_pkg::TAP_EX2_IR
                                          : bst_pkg::TAP_PAU_IR;
      bst_pkg::TAP_EX2_IR: tap_step = tms ? bst_pkg::TAP_UPD_IR
                                          : bst_pkg::TAP_SH_IR;
      bst_pkg::TAP_UPD_IR: tap_step = tms ? bst_pkg::TAP_SEL_DR
                                          : bst_pkg::TAP_IDLE;
      default: tap_step = bst_pkg::TAP_RESET;
    endcase
  endfunction

  always_comb begin
    s_next = s_reg;
    // Pins and pads reach logic only after two flops
    s_next.in_f = {reprogram_in_i, powerup_reset_in_i, tdi_i, tms_i, tck_i};
    s_next.in_q = s_reg.in_f; // R22 R24
    s_next.pad_f = pad_in_i;
    s_next.pad_q = s_reg.pad_f;
    s_next.tck_d = s_reg.in_q[0];
    rise = s_reg.in_q[0] & ~s_reg.tck_d;
    fall = ~s_reg.in_q[0] & s_reg.tck_d;
    rst_req = s_reg.in_q[3] | s_reg.in_q[4];
    active = ~s_reg.ctrl[`BST_CTRL_DONE] | s_reg.ctrl[`BST_CTRL_KEEP]; // R12
    bsr_on = (s_reg.ir == `BST_IR_EXTEST) | (s_reg.ir == `BST_IR_SAMPLE);
    s_next.strb = '0;
    s_next.cfg_wr = 1'b0;
    s_next.rb_shift = 1'b0;
    // Pad cells: data cell at 2p, direction cell at 2p+1
    for (int p = 0; p < NPADS; p++) begin
      u_dat[p] = s_reg.upd[2*p];
      u_dir[p] = s_reg.upd[2*p+1];
      cap[2*p+1] = s_reg.mode ? u_dir[p] : core_oe_i[p]; // R5 R6 R19
      cap[2*p] = cap[2*p+1] ? core_out_i[p] : s_reg.pad_q[p]; // R20
    end
    // Serial output source
    sout = s_reg.byp; // R4 R11
    if (s_reg.st == bst_pkg::TAP_SH_IR) begin
      sout = s_reg.ir_sh[0];
    end else begin
      case (s_reg.ir) // R1 R2 R3
        `BST_IR_EXTEST, `BST_IR_SAMPLE: sout = s_reg.boundary_chain[W-1]; // R10
        `BST_IR_RING1: sout = ring_sdo_i[0]; // R7
        `BST_IR_RING2: sout = ring_sdo_i[1]; // R7
        `BST_IR_RDBK: sout = s_reg.ctrl[`BST_CTRL_DONE] ? rb_bit_i
                                                         : s_reg.byp; // R9
        default: sout = s_reg.byp; // R4
      endcase
    end
    // Test port control
    if (rst_req || !active) begin
      s_next.st = bst_pkg::TAP_RESET; // R16
      s_next.ir = `BST_IR_BYPASS; // R13
    end else if (rise) begin
      s_next.st = tap_step(s_reg.st, s_reg.in_q[1]); // R15
      case (s_reg.st)
        bst_pkg::TAP_CAP_DR: begin
          s_next.strb.cap_dr = 1'b1; // R17
          s_next.byp = 1'b0;
          if (bsr_on) begin
            s_next.boundary_chain = cap; // R6
          end
        end
        bst_pkg::TAP_SH_DR: begin
          s_next.strb.sh_dr = 1'b1; // R17
          s_next.byp = s_reg.in_q[2]; // R11
          if (bsr_on) begin
            s_next.boundary_chain = {s_reg.boundary_chain[W-2:0], s_reg.in_q[2]}; // R10
          end
          if (s_reg.ir == `BST_IR_CFGW) begin
            s_next.cfg_wr = 1'b1; // R8
            s_next.cfg_bit = s_reg.in_q[2]; // R8
          end
          if (s_reg.ir == `BST_IR_RDBK && s_reg.ctrl[`BST_CTRL_DONE]) begin
            s_next.rb_shift = 1'b1; // R9
          end
        end
        bst_pkg::TAP_CAP_IR: begin
          s_next.strb.cap_ir = 1'b1; // R17
          s_next.ir_sh = `BST_IR_CAPT; // R13
        end
        bst_pkg::TAP_SH_IR: begin
          s_next.strb.sh_ir = 1'b1; // R17
          s_next.ir_sh = {s_reg.in_q[2], s_reg.ir_sh[2:1]}; // R1
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      // Output changes and updates happen on the falling edge
      s_next.tdo_oe = (s_reg.st == bst_pkg::TAP_SH_DR) |
                      (s_reg.st == bst_pkg::TAP_SH_IR); // R17 R22
      s_next.tdo = sout; // R22
      case (s_reg.st)
        bst_pkg::TAP_RESET: s_next.ir = `BST_IR_BYPASS; // R13
        bst_pkg::TAP_UPD_IR: begin
          s_next.strb.up_ir = 1'b1; // R17
          s_next.ir = s_reg.ir_sh; // R18
        end
        bst_pkg::TAP_UPD_DR: begin
          s_next.strb.up_dr = 1'b1; // R17
          if (bsr_on) begin
            s_next.upd = s_reg.boundary_chain; // R18 R23
          end
        end
        default: begin
        end
      endcase
    end
    s_next.strb.sel_ir = s_reg.st[3] & (s_reg.st != bst_pkg::TAP_UPD_DR) &
                         (s_reg.st != bst_pkg::TAP_UPD_IR); // R17
    if (!active) begin
      // Readback may still leave on the output pin
      s_next.tdo_oe = s_reg.ctrl[`BST_CTRL_RBO]; // R14
      s_next.tdo = rb_bit_i; // R14
    end
    s_next.user = active ? 3'h0 : s_reg.in_q[2:0]; // R14
    s_next.mode = (s_reg.ir == `BST_IR_EXTEST); // R21
    s_next.ring_sel = {s_reg.ir == `BST_IR_RING2,
                       s_reg.ir == `BST_IR_RING1}; // R7
    s_next.scan_tdi = s_reg.in_q[2];
    s_next.pout = s_reg.mode ? u_dat : core_out_i; // R5 R21 R23
    s_next.poe = s_reg.mode ? u_dir : core_oe_i; // R5
    // AXI4-Lite slave; write once both channels are held
    if (axi_req_i.awvalid && s_reg.rsp.awready) begin
      s_next.aw_ok = 1'b1;
      s_next.awa = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && s_reg.rsp.wready) begin
      s_next.w_ok = 1'b1;
      s_next.wd = axi_req_i.wdata;
      s_next.ws = axi_req_i.wstrb;
    end
    if (s_reg.rsp.bvalid && axi_req_i.bready) begin
      s_next.rsp.bvalid = 1'b0;
    end
    if (s_reg.aw_ok && s_reg.w_ok && !s_reg.rsp.bvalid) begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.rsp.bvalid = 1'b1;
      s_next.rsp.bresp = `BST_RESP_OKAY;
      if (s_reg.awa == `BST_CTRL_OFS) begin
        if (s_reg.ws[0]) begin
          s_next.ctrl = s_reg.wd[`BST_CTRL_W-1:0];
        end
      end else if (s_reg.awa != `BST_STAT_OFS) begin
        s_next.rsp.bresp = `BST_RESP_DECERR;
      end
    end
    s_next.rsp.awready = ~s_next.aw_ok & ~s_next.rsp.bvalid;
    s_next.rsp.wready = ~s_next.w_ok & ~s_next.rsp.bvalid;
    if (s_reg.rsp.rvalid && axi_req_i.rready) begin
      s_next.rsp.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && s_reg.rsp.arready) begin
      s_next.rsp.rvalid = 1'b1;
      s_next.rsp.rresp = `BST_RESP_OKAY;
      s_next.rsp.rdata = 32'h0;
      if (axi_req_i.araddr == `BST_CTRL_OFS) begin
        s_next.rsp.rdata[`BST_CTRL_W-1:0] = s_reg.ctrl;
      end else if (axi_req_i.araddr == `BST_STAT_OFS) begin
        s_next.rsp.rdata[`BST_STAT_ST +: 4] = s_reg.st;
        s_next.rsp.rdata[`BST_STAT_IR +: 3] = s_reg.ir;
        s_next.rsp.rdata[`BST_STAT_ACT] = active;
      end else begin
        s_next.rsp.rresp = `BST_RESP_DECERR;
      end
    end
    s_next.rsp.arready = ~s_next.rsp.rvalid;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
      s_reg.ir <= `BST_IR_BYPASS;
      s_reg.ctrl <= `BST_CTRL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tdo_o = s_reg.tdo;
  assign tdo_oe_o = s_reg.tdo_oe;
  assign user_pins_o = s_reg.user;
  assign pad_out_o = s_reg.pout;
  assign pad_oe_o = s_reg.poe;
  assign mode_o = s_reg.mode;
  assign strb_o = s_reg.strb;
  assign ring_sel_o = s_reg.ring_sel;
  assign scan_tdi_o = s_reg.scan_tdi;
  assign cfg_wr_o = s_reg.cfg_wr;
  assign cfg_bit_o = s_reg.cfg_bit;
  assign rb_shift_o = s_reg.rb_shift;
  assign axi_rsp_o = s_reg.rsp;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  tap_reset_a: assert property (rst_req |=> // R16
    s_reg.st == bst_pkg::TAP_RESET && s_reg.ir == `BST_IR_BYPASS)
    else $error("reset did not return tap to reset");
  tms_step_a: assert property (rise && active && !rst_req && // R15
    s_reg.st == bst_pkg::TAP_IDLE && s_reg.in_q[1] |=>
    s_reg.st == bst_pkg::TAP_SEL_DR)
    else $error("idle with mode select high did not advance");
  idcode_none_a: assert property (rise && active && !rst_req && // R13
    s_reg.st == bst_pkg::TAP_CAP_IR |=> s_reg.ir_sh == `BST_IR_CAPT)
    else $error("instruction capture value wrong");
  bypass_path_a: assert property (fall && active && !rst_req && // R11
    s_reg.st == bst_pkg::TAP_SH_DR && s_reg.ir == `BST_IR_BYPASS |=>
    tdo_oe_o && tdo_o == $past(s_reg.byp))
    else $error("bypass bit not on serial output");
  reserved_byp_a: assert property (fall && active && !rst_req && // R4
    s_reg.st == bst_pkg::TAP_SH_DR && s_reg.ir == `BST_IR_RSVD |=>
    tdo_o == $past(s_reg.byp))
    else $error("reserved code not bypassed");
  tdo_fall_a: assert property (active && $past(active) && // R22
    $changed(tdo_oe_o) |-> $past(fall))
    else $error("output enable moved off falling edge");
  extest_pads_a: assert property (mode_o && $past(mode_o) |-> // R23
    pad_oe_o == $past(u_dir) && pad_out_o == $past(u_dat))
    else $error("pads not driven from update flops");
  sample_pads_a: assert property ($past(resetn_i) && !$past(mode_o) |-> // R21
    pad_out_o == $past(core_out_i) && pad_oe_o == $past(core_oe_i))
    else $error("functional path disturbed outside extest");
  rdbk_gate_a: assert property (rb_shift_o |-> // R9
    $past(s_reg.ctrl[`BST_CTRL_DONE]) && $past(s_reg.ir) == `BST_IR_RDBK)
    else $error("readback before configuration done");
  cfg_bit_a: assert property (cfg_wr_o |-> // R8
    cfg_bit_o == $past(s_reg.in_q[2]) && $past(s_reg.ir) == `BST_IR_CFGW)
    else $error("config write bit mismatch");
  off_tdo_a: assert property (!active |=> // R14
    tdo_oe_o == $past(s_reg.ctrl[`BST_CTRL_RBO]))
    else $error("disabled output enable wrong");

  upd_ir_c: cover property (strb_o.up_ir);
  extest_c: cover property (mode_o && strb_o.up_dr);
  sample_c: cover property (s_reg.ir == `BST_IR_SAMPLE && strb_o.cap_dr);
  rdbk_c: cover property (rb_shift_o);
endmodule // bst_tap
`default_nettype wire

// ==== pkg/bst_defines.svh ====
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

// Register map
`define BST_AW 8
`define BST_CTRL_OFS 8'h00
`define BST_STAT_OFS 8'h04

// Control fields
`define BST_CTRL_DONE 0
`define BST_CTRL_KEEP 1
`define BST_CTRL_RBO 2
`define BST_CTRL_W 3
`define BST_CTRL_RST 3'h0

// Status fields
`define BST_STAT_ST 0
`define BST_STAT_IR 4
`define BST_STAT_ACT 8

// Instruction codes
`define BST_IR_EXTEST 3'h0
`define BST_IR_RING1 3'h1
`define BST_IR_CFGW 3'h2
`define BST_IR_RSVD 3'h3
`define BST_IR_SAMPLE 3'h4
`define BST_IR_RING2 3'h5
`define BST_IR_RDBK 3'h6
`define BST_IR_BYPASS 3'h7
`define BST_IR_CAPT 3'h1

// Bus answers
`define BST_RESP_OKAY 2'h0
`define BST_RESP_DECERR 2'h3

`endif

// ==== pkg/bst_pkg.sv ====
`default_nettype none
package bst_pkg;
`include "bst_defines.svh"

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h3,
    TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6,
    TAP_EX1_DR = 4'h7,
    TAP_PAU_DR = 4'h5,
    TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hc,
    TAP_SEL_IR = 4'hd,
    TAP_CAP_IR = 4'hf,
    TAP_SH_IR = 4'he,
    TAP_EX1_IR = 4'ha,
    TAP_PAU_IR = 4'hb,
    TAP_EX2_IR = 4'h9,
    TAP_UPD_IR = 4'h8
  } bst_tap_t;

  typedef struct packed {
    logic sel_ir;
    logic cap_dr;
    logic cap_ir;
    logic sh_dr;
    logic sh_ir;
    logic up_dr;
    logic up_ir;
  } bst_strb_t;

  typedef struct packed {
    logic [`BST_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [`BST_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } bst_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } bst_axi_rsp_t;
endpackage
`default_nettype wire
